// ### logic/rtcac_pkg.sv
// Constants for the time access coherence block
package rtcac_pkg;
	// Clock rate
	localparam int unsigned CLK_HZ = 50000000;
	// Bus access timeout in milliseconds, and the derived cycle count
	localparam int unsigned TIMEOUT_MS = 950;
	localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	// Prescaler: stages from 4096 Hz down to 1 Hz
	localparam int unsigned PRESC_BITS = 12;
	localparam logic [11:0] PRESC_RST = 12'h000;
	// Register pointer layout and the first and last frozen registers
	localparam int unsigned PTR_BITS = 8;
	localparam logic [7:0] REG_HUNDREDTHS = 8'h00;
	localparam logic [7:0] REG_SECONDS = 8'h01;
	localparam logic [7:0] REG_YEAR = 8'h07;
	localparam logic [7:0] PTR_RST = 8'h00;
	// Hundredths counter limit and reset value
	localparam logic [6:0] HUND_MAX = 7'h63;
	localparam logic [6:0] HUND_RST = 7'h00;
	// Read data returned after a timeout
	localparam logic [7:0] READ_TIMEOUT_DATA = 8'hff;
	// Hundredths tick: 4096 Hz ticks per hundredth (41 approximates 40.96)
	localparam logic [5:0] HUND_DIV = 6'h28;
	// Access states
	typedef enum logic [1:0] {
		RTCAC_IDLE,
		RTCAC_ACCESS,
		RTCAC_ABORTED
	} rtcac_state_t;
endpackage

// ### logic/rtcac_prescaler.sv
// Prescaler chain from the 4096 Hz tick down to 1 Hz, with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module rtcac_prescaler #(
	parameter int unsigned BITS = rtcac_pkg::PRESC_BITS
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            tick_4096,
	input  wire logic            clear,
	output logic [BITS-1:0]      stages,
	output logic                 tick_1hz
);
	logic [BITS-1:0] count;
	logic [BITS-1:0] next_count;
	logic            next_tick;

	// Next count; a clear restarts every stage and drops the pending carry
	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (clear) begin
			next_count = '0;
		end else if (tick_4096) begin
			next_count = count + 1'b1;
			next_tick = &count;
		end
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= BITS'(rtcac_pkg::PRESC_RST);
			tick_1hz <= 1'b0;
		end else begin
			count <= next_count;
			tick_1hz <= next_tick;
		end
	end

	assign stages = count;
endmodule
`default_nettype wire

// ### logic/rtcac_core.sv
// Time access coherence: freezes time counters during a bus access
// Notes on behaviour
// - During a short bus access freeze time counters, suppress time_inc; tick_1hz and hundredths run.
// - Hold one 1 Hz tick during the freeze and apply it after STOP.
// - Stop toggle, synced event or seconds write drops held tick, resets prescaler.
// - Prescaler reset shifts the period of every prescaler consumer.
// - A seconds write also clears the hundredths counter to 00.
// - Write beyond 950 ms: interface reset, contents kept, held tick applied.
// - Read beyond 950 ms: bytes read return FFh, held tick applied.
// - After timeout ignore the rest of the transfer until a fresh START.
// - Register pointer keeps its value across STOP and timeout stop.
// - Time set without seconds write applies held tick, keeps prescaler phase.
// - Stop toggle and synced event reset prescaler without changing seconds.
`timescale 1ns/10ps
`default_nettype none
module rtcac_core #(
	parameter int unsigned TIMEOUT_CYC = rtcac_pkg::TIMEOUT_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        tick_4096,
	input  wire logic        bus_start,
	input  wire logic        bus_stop,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_ptr_load,
	input  wire logic [7:0]  bus_ptr_value,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic        stop_bit,
	input  wire logic        external_event_input,
	input  wire logic        event_sync_enable,
	output logic [7:0]       bus_rdata,
	output logic             bus_ignore,
	output logic             bus_if_reset,
	output logic [7:0]       reg_ptr,
	output logic             reg_write,
	output logic [7:0]       reg_wdata,
	output logic             time_freeze,
	output logic             time_inc,
	output logic [6:0]       hundredths,
	output logic [11:0]      presc_stages,
	output logic             presc_clear,
	output logic             tick_1hz
);
	localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

	rtcac_pkg::rtcac_state_t state;
	rtcac_pkg::rtcac_state_t next_state;
	logic [TW-1:0] tmo_cnt;
	logic [TW-1:0] next_tmo_cnt;
	logic          held;
	logic          next_held;
	logic [7:0]    next_reg_ptr;
	logic [6:0]    next_hundredths;
	logic [5:0]    hdiv;
	logic [5:0]    next_hdiv;
	logic          next_time_inc;
	logic          next_if_reset;
	logic [7:0]    next_bus_rdata;
	logic          stop_bit_d;
	logic          next_stop_bit_d;
	logic          evi_meta;
	logic          evi_sync;
	logic          evi_d;
	logic          stop_toggle;
	logic          sync_event;
	logic          sec_write;
	logic          in_access;
	logic          raw_tick;

	// Prescaler shared by every consumer of the 4096 Hz to 1 Hz stages
	rtcac_prescaler #(
		.BITS (rtcac_pkg::PRESC_BITS)
	) u_presc (
		.clk       (clk),
		.rst_n     (rst_n),
		.tick_4096 (tick_4096),
		.clear     (presc_clear),
		.stages    (presc_stages),
		.tick_1hz  (raw_tick)
	);

	// Event pin comes from outside, so it passes two flops first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evi_meta <= 1'b0;
			evi_sync <= 1'b0;
			evi_d <= 1'b0;
		end else begin
			evi_meta <= external_event_input;
			evi_sync <= evi_meta;
			evi_d <= evi_sync;
		end
	end

	// Synchronisation triggers
	assign next_stop_bit_d = stop_bit;
	assign stop_toggle = stop_bit && !stop_bit_d;
	assign sync_event = event_sync_enable && evi_sync && !evi_d;
	assign in_access = (state == rtcac_pkg::RTCAC_ACCESS);
	assign sec_write = in_access && bus_wr && (reg_ptr == rtcac_pkg::REG_SECONDS);
	// One clear feeds the shared prescaler, so all consumers see it
	assign presc_clear = stop_toggle || sync_event || sec_write;
	assign tick_1hz = raw_tick;
	assign bus_ignore = (state == rtcac_pkg::RTCAC_ABORTED);
	assign reg_write = in_access && bus_wr;
	assign reg_wdata = bus_wdata;

	// Access sequencing, timeout and held tick
	always_comb begin
		next_state = state;
		next_tmo_cnt = tmo_cnt;
		next_held = held;
		next_time_inc = 1'b0;
		next_if_reset = 1'b0;
		next_reg_ptr = reg_ptr;
		next_bus_rdata = bus_rdata;
		// Frozen while an access lasts; plain ticks count when idle or aborted
		if (state != rtcac_pkg::RTCAC_ACCESS && raw_tick) begin
			next_time_inc = 1'b1;
		end
		case (state)
			rtcac_pkg::RTCAC_IDLE: begin
				if (bus_start) begin
					next_state = rtcac_pkg::RTCAC_ACCESS;
					next_tmo_cnt = '0;
					next_time_inc = raw_tick;
				end
			end
			rtcac_pkg::RTCAC_ACCESS: begin
				next_tmo_cnt = tmo_cnt + 1'b1;
				if (raw_tick) begin
					next_held = 1'b1;
				end
				if (presc_clear) begin
					next_held = 1'b0;
				end
				if (bus_ptr_load) begin
					next_reg_ptr = bus_ptr_value;
				end else if (bus_wr || bus_rd) begin
					next_reg_ptr = reg_ptr + 8'h01;
				end
				if (bus_rd) begin
					next_bus_rdata = reg_rdata;
				end
				if (tmo_cnt >= TW'(TIMEOUT_CYC - 1)) begin
					// Contents stay as written; held tick still lands
					next_state = rtcac_pkg::RTCAC_ABORTED;
					next_if_reset = 1'b1;
					// A clear in the abort cycle drops the held tick, as at STOP
					next_time_inc = (held || raw_tick) && !presc_clear;
					next_held = 1'b0;
				end else if (bus_stop) begin
					next_state = rtcac_pkg::RTCAC_IDLE;
					next_time_inc = (held || raw_tick) && !presc_clear;
					next_held = 1'b0;
				end
			end
			rtcac_pkg::RTCAC_ABORTED: begin
				if (bus_rd) begin
					next_bus_rdata = rtcac_pkg::READ_TIMEOUT_DATA;
				end
				// Only a fresh START resumes; pointer is left alone
				if (bus_start) begin
					next_state = rtcac_pkg::RTCAC_ACCESS;
					next_tmo_cnt = '0;
				end else if (bus_stop) begin
					next_state = rtcac_pkg::RTCAC_IDLE;
				end
			end
			default: begin
				next_state = rtcac_pkg::RTCAC_IDLE;
			end
		endcase
	end

	// Hundredths keep running through any access
	always_comb begin
		next_hdiv = hdiv;
		next_hundredths = hundredths;
		if (sec_write || presc_clear) begin
			next_hdiv = '0;
		end else if (tick_4096) begin
			next_hdiv = (hdiv == rtcac_pkg::HUND_DIV) ? 6'h00 : hdiv + 6'h01;
		end
		if (sec_write) begin
			next_hundredths = rtcac_pkg::HUND_RST;
		end else if (raw_tick) begin
			next_hundredths = rtcac_pkg::HUND_RST;
		end else if (tick_4096 && hdiv == rtcac_pkg::HUND_DIV &&
				hundredths != rtcac_pkg::HUND_MAX) begin
			next_hundredths = hundredths + 7'h01;
		end
	end

	// Register all state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= rtcac_pkg::RTCAC_IDLE;
			tmo_cnt <= '0;
			held <= 1'b0;
			time_inc <= 1'b0;
			bus_if_reset <= 1'b0;
			reg_ptr <= rtcac_pkg::PTR_RST;
			bus_rdata <= 8'h00;
			stop_bit_d <= 1'b0;
			hdiv <= 6'h00;
			hundredths <= rtcac_pkg::HUND_RST;
		end else begin
			state <= next_state;
			tmo_cnt <= next_tmo_cnt;
			held <= next_held;
			time_inc <= next_time_inc;
			bus_if_reset <= next_if_reset;
			reg_ptr <= next_reg_ptr;
			bus_rdata <= next_bus_rdata;
			stop_bit_d <= next_stop_bit_d;
			hdiv <= next_hdiv;
			hundredths <= next_hundredths;
		end
	end

	assign time_freeze = in_access;
endmodule
`default_nettype wire

// ### dv/rtcac_chk.sv
// Port checker for the time access coherence block
`timescale 1ns/10ps
`default_nettype none
module rtcac_chk #(
	parameter int unsigned TIMEOUT_CYC = 200
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        bus_stop,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic        bus_ptr_load,
	input wire logic [7:0]  bus_wdata,
	input wire logic        stop_bit,
	input wire logic        external_event_input,
	input wire logic        event_sync_enable,
	input wire logic [7:0]  bus_rdata,
	input wire logic        bus_ignore,
	input wire logic        bus_if_reset,
	input wire logic [7:0]  reg_ptr,
	input wire logic        reg_write,
	input wire logic [7:0]  reg_wdata,
	input wire logic        time_freeze,
	input wire logic        time_inc,
	input wire logic [6:0]  hundredths,
	input wire logic [11:0] presc_stages,
	input wire logic        presc_clear,
	input wire logic        tick_1hz
);
	logic        held;
	int unsigned acc_cnt;
	// Held tick shadow; conservative when a clear meets a tick
	always_ff @(posedge clk) begin
		held <= rst_n && time_freeze && !presc_clear && (held || tick_1hz);
		acc_cnt <= (rst_n && time_freeze) ? acc_cnt + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence sec_wr_s;
		reg_write && reg_ptr == rtcac_pkg::REG_SECONDS;
	endsequence
	sequence held_stop_s;
		bus_stop && time_freeze && held && !presc_clear;
	endsequence
	freeze_hold_a: assert property (time_freeze && $past(time_freeze) |-> !time_inc)
		else $error("time advanced in freeze");
	unfreeze_a: assert property (bus_stop |=> !time_freeze)
		else $error("freeze kept after stop");
	held_apply_a: assert property (held_stop_s |=> time_inc)
		else $error("held tick lost");
	sec_clear_a: assert property (sec_wr_s |-> presc_clear ##1 hundredths == 7'h00)
		else $error("seconds write side effects missing");
	presc_zero_a: assert property (presc_clear |=> presc_stages == rtcac_pkg::PRESC_RST)
		else $error("prescaler not restarted");
	toggle_clr_a: assert property ($rose(stop_bit) |-> presc_clear)
		else $error("stop toggle ignored");
	event_clr_a: assert property ($rose(external_event_input) && event_sync_enable
		|-> ##[2:4] presc_clear)
		else $error("synced event ignored");
	abort_rd_a: assert property (bus_ignore && bus_rd |=> bus_rdata == 8'hff)
		else $error("aborted read not all ones");
	abort_wr_a: assert property (bus_ignore |-> !reg_write)
		else $error("aborted write reached registers");
	ptr_keep_a: assert property (bus_stop && !bus_ptr_load && !bus_wr && !bus_rd
		|=> $stable(reg_ptr))
		else $error("pointer moved at stop");
	timeout_a: assert property (acc_cnt <= TIMEOUT_CYC)
		else $error("access outlived timeout");
	abort_tick_a: assert property ((held || tick_1hz) && time_freeze && !presc_clear ##1 bus_if_reset
		|-> time_inc)
		else $error("held tick lost at timeout");
	ifreset_abort_a: assert property (bus_if_reset |-> bus_ignore && !time_freeze)
		else $error("interface reset without abort");
	wdata_pass_a: assert property (reg_write |-> reg_wdata == bus_wdata)
		else $error("write data altered");
endmodule
bind rtcac_core rtcac_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) rtcac_chk_i (.*);
`default_nettype wire

// ### dv/rtcac_host.sv
// Serial host model issuing bus events to the coherence block
`timescale 1ns/10ps
`default_nettype none
module rtcac_host (
	input  wire logic clk,
	output logic       bus_start,
	output logic       bus_stop,
	output logic       bus_wr,
	output logic       bus_rd,
	output logic       bus_ptr_load,
	output logic [7:0] bus_wdata,
	output logic [7:0] bus_ptr_value,
	output logic [7:0] reg_rdata
);
	logic [7:0] exp_q[$];
	initial begin
		{bus_start, bus_stop, bus_wr, bus_rd, bus_ptr_load} = 5'h00;
		{bus_wdata, bus_ptr_value, reg_rdata} = 24'h5a5a5a;
	end
	// One event per call: 0 start, 1 stop, 2 write, 3 read, 4 pointer
	task automatic op(input int k, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		{bus_start, bus_stop, bus_wr, bus_rd, bus_ptr_load} <= 5'h10 >> k;
		{bus_wdata, bus_ptr_value, reg_rdata} <= {3{d}};
		if (k == 3) begin
			exp_q.push_back(e);
		end
		@(posedge clk);
		{bus_start, bus_stop, bus_wr, bus_rd, bus_ptr_load} <= 5'h00;
		// Stale data would hide a late sample, so invert it
		{bus_wdata, bus_ptr_value, reg_rdata} <= {3{~d}};
	endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Testbench for the time access coherence block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk, rst_n, tick_4096, stop_bit, external_event_input, event_sync_enable;
	logic bus_start, bus_stop, bus_wr, bus_rd, bus_ptr_load, rd_d;
	logic [7:0] bus_wdata, bus_ptr_value, reg_rdata, bus_rdata, reg_ptr, reg_wdata, v;
	logic bus_ignore, bus_if_reset, reg_write, time_freeze, time_inc, presc_clear, tick_1hz;
	logic [6:0] hundredths;
	logic [11:0] presc_stages;
	int fails = 0;
	int n_tests = 0;
	// Short timeout keeps the abort case quick
	rtcac_core #(.TIMEOUT_CYC(200)) rtcac_core_i (.*);
	rtcac_host rtcac_host_i (.*);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic h(input int k, input logic [7:0] d);
		rtcac_host_i.op(k, d, d);
		#1;
	endtask
	// Bounded wait until the prescaler nears its wrap or ticks
	task automatic wait_for(input logic tk);
		for (int i = 0; i < 5000 && (tk ? tick_1hz !== 1'b1 : presc_stages < 12'hfc0); i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	// Oldest read note is compared when read data lands
	always @(posedge clk) begin
		if (rd_d === 1'b1) begin
			chk("bus_rdata", {4'h0, rtcac_host_i.exp_q.pop_front()}, {4'h0, bus_rdata});
		end
		rd_d <= bus_rd;
	end
	initial begin
		#1000000;
		fails++;
		tally_and_finish();
	end
	initial begin
		v = $urandom(49543);
		{rst_n, stop_bit, external_event_input} = 3'h0;
		{tick_4096, event_sync_enable} = 2'b11;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// Stop toggle, then synced event, each restart the prescaler
		for (int s = 0; s < 2; s++) begin
			repeat (30) @(posedge clk);
			{stop_bit, external_event_input} <= s ? 2'b01 : 2'b10;
			repeat (5) @(posedge clk);
			#1 chk("presc_restart", 1, presc_stages < 12'h008);
			@(posedge clk);
			{stop_bit, external_event_input} <= 2'b00;
		end
		// Read, plain time write, seconds write, each across a 1 Hz wrap
		for (int s = 0; s < 3; s++) begin
			wait_for(1'b0);
			h(0, 8'h00);
			h(4, (s == 1) ? 8'h02 : 8'h01);
			wait_for(1'b1);
			v = $urandom;
			if (s == 2) begin
				repeat (60) @(posedge clk);
			end
			h((s == 0) ? 3 : 2, v);
			if (s == 2) begin
				chk("hundredths", 0, hundredths);
				// A 00 or 99 reading may straddle a carry, so reread until two agree
				v = {1'b0, hundredths};
				for (int r = 0; r < 3 && (v == 8'h00 || v == 8'h63); r++) begin
					@(posedge clk);
					#1;
					if (v == {1'b0, hundredths}) begin
						break;
					end
					v = {1'b0, hundredths};
				end
				chk("hundredths_reread", 0, v);
			end
			h(1, 8'h00);
			chk("time_inc", s != 2, time_inc);
			chk("reg_ptr", (s == 1) ? 8'h03 : 8'h02, reg_ptr);
		end
		// Overlong access aborts; a tick held inside it lands at the timeout
		wait_for(1'b0);
		h(0, 8'h00);
		h(4, 8'h05);
		repeat (197) @(posedge clk);
		#1 chk("time_freeze", 1, time_freeze);
		@(posedge clk);
		#1 chk("time_freeze", 0, time_freeze);
		chk("bus_if_reset", 1, bus_if_reset);
		chk("time_inc", 1, time_inc);
		repeat (2) @(posedge clk);
		#1 chk("bus_ignore", 1, bus_ignore);
		chk("bus_if_reset", 0, bus_if_reset);
		chk("reg_ptr", 8'h05, reg_ptr);
		rtcac_host_i.op(3, v, 8'hff);
		h(2, v);
		h(0, 8'h00);
		chk("bus_ignore", 0, bus_ignore);
		h(1, 8'h00);
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
